// ===== design/fpsc_shifter.sv
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - step size is period/256 or one tap
// - one delay shifts all outputs together
// - fine delay adds onto coarse phase offset
// - mode is disabled, fixed or variable
// - disabled mode applies zero shift
// - delay equals shift/256 times reference period
// - positive delays feedback, negative advances it
// - tap range limits usable shift
// - variable mode starts from initial shift
// - step edges count only while enabled
// - direction high adds, low subtracts one step
// - done pulses three step cycles after settling, for one step cycle
// - manager reset restores initial shift
// - net count confined to -255..+255
// - step inputs have selectable polarity
// - overflow flag on range or tap exhaustion
// - manager reset active high, asynchronous
module fpsc_shifter #(
  parameter int TAP_PS     = 40,
  parameter int NUM_TAPS   = 256,
  parameter int PERIOD_W   = 12,
  parameter int SETTLE_REF = fpsc_pkg::SETTLE_REF_CYCLES
) (
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // manager reset
  input  wire logic        manager_reset,
  // clocks under control
  input  wire logic        reference_clock_in,
  input  wire logic        feedback_clock_in,
  // step port
  input  wire logic        step_enable,
  input  wire logic        step_clock,
  input  wire logic        step_direction,
  output logic             step_done,
  // delay line control
  output logic signed [31:0] fine_delay_time,
  output logic [$clog2(NUM_TAPS+1)-1:0] tap_select
);

  localparam int TAP_W  = $clog2(NUM_TAPS + 1);
  localparam int WAIT_W = $clog2(SETTLE_REF + 1);

  // ****************************************
  // state types
  // ****************************************
  typedef struct packed {
    logic [1:0]        mode;
    logic [2:0]        pol;
    logic [1:0]        coarse;
    logic signed [8:0] init;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } fpsc_cfg_t;

  typedef struct packed {
    logic [2:0]           sclk;
    logic [2:0]           sen;
    logic [2:0]           sdir;
    logic [2:0]           sref;
    logic [2:0]           sfb;
    logic [PERIOD_W-1:0]  period_cnt;
    logic [PERIOD_W-1:0]  period;
    logic [PERIOD_W-1:0]  fb_lag;
    logic signed [8:0]    net;
    fpsc_pkg::fpsc_state_t state;
    logic [WAIT_W-1:0]    wait_cnt;
    logic [1:0]           trail_cnt;
    logic                 done;
    logic                 ovf;
    logic signed [31:0]   delay_ps;
    logic [TAP_W-1:0]     taps;
  } fpsc_core_t;

  fpsc_cfg_t  cfg_ff;
  fpsc_cfg_t  nxt_cfg;
  fpsc_core_t core_ff;
  fpsc_core_t nxt_core;

  logic                core_rst_n;
  logic                acc;
  logic                wr;
  logic                hit;
  logic [31:0]         rd_data;
  logic                clk_rise;
  logic                en_at;
  logic                dir_at;
  logic                ref_rise;
  logic                fb_rise;
  logic signed [9:0]   cur_shift;
  logic signed [9:0]   cand_shift;
  logic signed [9:0]   cand_net;
  logic signed [31:0]  cand_ps;
  logic [31:0]         cur_taps;
  logic signed [10:0]  coarse_sum;

  // ****************************************
  // arithmetic helpers
  // ****************************************
  function automatic logic signed [9:0] applied_shift(
    input logic [1:0]        mode,
    input logic signed [8:0] init,
    input logic signed [9:0] net
  );
    logic signed [9:0] res;
    res = '0;
    case (fpsc_pkg::fpsc_mode_t'(mode))
      fpsc_pkg::FPSC_MODE_FIXED: res = 10'(init);
      fpsc_pkg::FPSC_MODE_VAR:   res = 10'(init) + net;
      default:                   res = '0;
    endcase
    return res;
  endfunction

  function automatic logic signed [31:0] delay_ps_of(
    input logic signed [9:0]   shift,
    input logic [PERIOD_W-1:0] period
  );
    logic signed [39:0] prod;
    prod = 40'(shift) * $signed({1'b0, 39'(period)});
    prod = prod * 40'(fpsc_pkg::PCLK_PERIOD_PS);
    return 32'(prod / 40'(fpsc_pkg::STEP_DIV));
  endfunction

  function automatic logic [31:0] taps_of(input logic signed [31:0] ps);
    logic [31:0] mag;
    mag = ps[31] ? 32'(-ps) : 32'(ps);
    return mag / 32'(TAP_PS);
  endfunction

  function automatic logic out_of_range(input logic signed [9:0] val);
    return (val > 10'(fpsc_pkg::SHIFT_LIMIT)) || (val < -10'(fpsc_pkg::SHIFT_LIMIT));
  endfunction

  // ****************************************
  // register read decode
  // ****************************************
  always_comb begin
    rd_data = 32'h0000_0000;
    hit     = 1'b1;
    if (paddr == fpsc_pkg::REG_CTRL) begin
      rd_data[fpsc_pkg::CTRL_MODE_LSB +: 2]   = cfg_ff.mode;
      rd_data[fpsc_pkg::CTRL_POL_EN +: 3]     = cfg_ff.pol;
      rd_data[fpsc_pkg::CTRL_COARSE_LSB +: 2] = cfg_ff.coarse;
    end else if (paddr == fpsc_pkg::REG_INIT) begin
      rd_data = 32'(cfg_ff.init);
    end else if (paddr == fpsc_pkg::REG_STATUS) begin
      rd_data[fpsc_pkg::STATUS_OVF]  = core_ff.ovf;
      rd_data[fpsc_pkg::STATUS_BUSY] = core_ff.state != fpsc_pkg::FPSC_IDLE;
    end else if (paddr == fpsc_pkg::REG_SHIFT) begin
      rd_data = 32'(core_ff.net);
    end else if (paddr == fpsc_pkg::REG_DELAY) begin
      rd_data = core_ff.delay_ps;
    end else if (paddr == fpsc_pkg::REG_TAPS) begin
      rd_data = 32'(core_ff.taps);
    end else if (paddr == fpsc_pkg::REG_PERIOD) begin
      rd_data = 32'(core_ff.period);
    end else if (paddr == fpsc_pkg::REG_COARSE) begin
      rd_data = 32'(coarse_sum);
    end else if (paddr == fpsc_pkg::REG_FBLAG) begin
      rd_data = 32'(core_ff.fb_lag);
    end else begin
      hit = 1'b0;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_cfg  = cfg_ff;
    nxt_core = core_ff;
    acc      = psel & penable;
    wr       = acc & pwrite & cfg_ff.pready;

    // apb: one wait state, data and error with pready
    nxt_cfg.pready  = acc & ~cfg_ff.pready;
    nxt_cfg.pslverr = acc & ~cfg_ff.pready & ~hit;
    if (acc && !cfg_ff.pready) begin
      nxt_cfg.prdata = rd_data;
    end
    if (wr && paddr == fpsc_pkg::REG_CTRL) begin
      nxt_cfg.mode   = pwdata[fpsc_pkg::CTRL_MODE_LSB +: 2];
      nxt_cfg.pol    = pwdata[fpsc_pkg::CTRL_POL_EN +: 3];
      nxt_cfg.coarse = pwdata[fpsc_pkg::CTRL_COARSE_LSB +: 2];
    end
    if (wr && paddr == fpsc_pkg::REG_INIT) begin
      nxt_cfg.init = $signed(pwdata[8:0]);
    end

    // synchronisers
    nxt_core.sclk = {core_ff.sclk[1:0], step_clock};
    nxt_core.sen  = {core_ff.sen[1:0], step_enable};
    nxt_core.sdir = {core_ff.sdir[1:0], step_direction};
    nxt_core.sref = {core_ff.sref[1:0], reference_clock_in};
    nxt_core.sfb  = {core_ff.sfb[1:0], feedback_clock_in};

    clk_rise = (core_ff.sclk[1] ^ cfg_ff.pol[1]) & ~(core_ff.sclk[2] ^ cfg_ff.pol[1]);
    en_at    = core_ff.sen[2] ^ cfg_ff.pol[0];
    dir_at   = core_ff.sdir[2] ^ cfg_ff.pol[2];
    ref_rise = core_ff.sref[1] & ~core_ff.sref[2];
    fb_rise  = core_ff.sfb[1] & ~core_ff.sfb[2];

    // reference period and feedback lag in pclk cycles
    if (ref_rise) begin
      nxt_core.period     = core_ff.period_cnt + PERIOD_W'(1);
      nxt_core.period_cnt = '0;
    end else if (core_ff.period_cnt != '1) begin
      nxt_core.period_cnt = core_ff.period_cnt + PERIOD_W'(1);
    end
    if (fb_rise) begin
      nxt_core.fb_lag = core_ff.period_cnt;
    end

    cur_shift = applied_shift(cfg_ff.mode, cfg_ff.init, 10'(core_ff.net));
    nxt_core.delay_ps = delay_ps_of(cur_shift, core_ff.period);
    cur_taps          = taps_of(core_ff.delay_ps);
    // one tap select feeds the common delay line
    nxt_core.taps = (cur_taps > 32'(NUM_TAPS)) ? TAP_W'(NUM_TAPS) : TAP_W'(cur_taps);
    coarse_sum = 11'(cfg_ff.coarse) * 11'(fpsc_pkg::COARSE_QUARTER) + 11'(cur_shift);

    cand_net   = 10'(core_ff.net) + (dir_at ? 10'sd1 : -10'sd1);
    cand_shift = applied_shift(cfg_ff.mode, cfg_ff.init, cand_net);
    cand_ps    = delay_ps_of(cand_shift, core_ff.period);

    if (wr && paddr == fpsc_pkg::REG_STATUS && pwdata[fpsc_pkg::STATUS_OVF]) begin
      nxt_core.ovf = 1'b0;
    end
    if (cur_taps >= 32'(NUM_TAPS)) begin
      nxt_core.ovf = 1'b1;
    end

    case (core_ff.state)
      fpsc_pkg::FPSC_IDLE: begin
        nxt_core.done = 1'b0;
        // only variable mode listens to step inputs
        // enabled step clock edge with direction
        if (fpsc_pkg::fpsc_mode_t'(cfg_ff.mode) == fpsc_pkg::FPSC_MODE_VAR && clk_rise
            && en_at) begin
          if (out_of_range(cand_net) || out_of_range(cand_shift)
              || taps_of(cand_ps) > 32'(NUM_TAPS)) begin
            nxt_core.ovf = 1'b1;
          end else begin
            nxt_core.net = 9'(cand_net);
          end
          nxt_core.wait_cnt = '0;
          nxt_core.state    = fpsc_pkg::FPSC_SETTLE;
        end
      end
      fpsc_pkg::FPSC_SETTLE: begin
        if (ref_rise) begin
          if (core_ff.wait_cnt == WAIT_W'(SETTLE_REF - 1)) begin
            nxt_core.trail_cnt = '0;
            nxt_core.state     = fpsc_pkg::FPSC_TRAIL;
          end else begin
            nxt_core.wait_cnt = core_ff.wait_cnt + WAIT_W'(1);
          end
        end
      end
      fpsc_pkg::FPSC_TRAIL: begin
        if (clk_rise) begin
          if (core_ff.trail_cnt == 2'(fpsc_pkg::TRAIL_STEP_CYCLES - 1)) begin
            nxt_core.done  = 1'b1;
            nxt_core.state = fpsc_pkg::FPSC_DONE;
          end else begin
            nxt_core.trail_cnt = core_ff.trail_cnt + 2'd1;
          end
        end
      end
      fpsc_pkg::FPSC_DONE: begin
        // requests before this point were dropped
        if (clk_rise) begin
          nxt_core.done  = 1'b0;
          nxt_core.state = fpsc_pkg::FPSC_IDLE;
        end
      end
      default: nxt_core.state = fpsc_pkg::FPSC_IDLE;
    endcase

    if (wr && (paddr == fpsc_pkg::REG_CTRL || paddr == fpsc_pkg::REG_INIT)) begin
      nxt_core.net   = '0;
      nxt_core.done  = 1'b0;
      nxt_core.state = fpsc_pkg::FPSC_IDLE;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff        <= '0;
      cfg_ff.mode   <= fpsc_pkg::MODE_RST;
      cfg_ff.pol    <= fpsc_pkg::POL_RST;
      cfg_ff.coarse <= fpsc_pkg::COARSE_RST;
      cfg_ff.init   <= fpsc_pkg::INIT_RST;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // manager reset acts without the clock
  assign core_rst_n = presetn & ~manager_reset;

  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      core_ff       <= '0;
      core_ff.state <= fpsc_pkg::FPSC_IDLE;
    end else begin
      core_ff <= nxt_core;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata          = cfg_ff.prdata;
  assign pready          = cfg_ff.pready;
  assign pslverr         = cfg_ff.pslverr;
  assign step_done       = core_ff.done;
  // sign of delay gives later or earlier feedback
  assign fine_delay_time = core_ff.delay_ps;
  assign tap_select      = core_ff.taps;

endmodule

// ===== design/fpsc_pkg.sv
package fpsc_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_INIT   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_SHIFT  = 8'h0C;
  localparam logic [7:0] REG_DELAY  = 8'h10;
  localparam logic [7:0] REG_TAPS   = 8'h14;
  localparam logic [7:0] REG_PERIOD = 8'h18;
  localparam logic [7:0] REG_COARSE = 8'h1C;
  localparam logic [7:0] REG_FBLAG  = 8'h20;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_POL_EN     = 2;
  localparam int CTRL_POL_CLK    = 3;
  localparam int CTRL_POL_DIR    = 4;
  localparam int CTRL_COARSE_LSB = 5;
  localparam int STATUS_OVF      = 0;
  localparam int STATUS_BUSY     = 1;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [1:0]        MODE_RST   = 2'h0;
  localparam logic [2:0]        POL_RST    = 3'h0;
  localparam logic [1:0]        COARSE_RST = 2'h0;
  localparam logic signed [8:0] INIT_RST   = 9'h000;

  // ****************************************
  // shift arithmetic and timing
  // ****************************************
  localparam int SHIFT_LIMIT       = 255;
  localparam int STEP_DIV          = 256;
  localparam int COARSE_QUARTER    = 64;
  localparam int PCLK_PERIOD_PS    = 4000;
  localparam int SETTLE_REF_CYCLES = 100;
  localparam int TRAIL_STEP_CYCLES = 3;

  // ****************************************
  // modes and states
  // ****************************************
  typedef enum logic [1:0] {FPSC_MODE_OFF, FPSC_MODE_FIXED, FPSC_MODE_VAR} fpsc_mode_t;
  typedef enum logic [1:0] {FPSC_IDLE, FPSC_SETTLE, FPSC_TRAIL, FPSC_DONE} fpsc_state_t;

endpackage

// ===== verif/fpsc_step_model.sv
`timescale 1ns/1ps
// ****
// step request source
// ****
module fpsc_step_model (
  // step port
  output logic      step_enable,
  output logic      step_clock,
  output logic      step_direction,
  input  wire logic step_done
);
  initial begin
    step_enable    = 1'b0;
    step_clock     = 1'b0;
    step_direction = 1'b0;
  end
  task automatic step(input logic act, req, dir, again, output int highs);
    int k;
    highs = 0;
    #7;
    for (k = 0; k < 24; k++) begin
      step_enable    = (req && (k == 0 || (again && highs == 0))) ? act : !act;
      step_direction = dir;
      #40 step_clock = 1'b1;
      #40 step_clock = 1'b0;
      #40;
      if (step_done === 1'b1) highs++;
      else if (highs > 0) break;
      #40;
    end
    step_enable    = 1'b0;
    step_direction = 1'b0;
  endtask
endmodule

// ===== verif/fpsc_shifter_checker.sv
`timescale 1ns/1ps
// ****
// port checks
// ****
module fpsc_shifter_checker #(
  parameter int NUM_TAPS = 256
) (
  // apb
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic [7:0]                    paddr,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [31:0]                   pwdata,
  input wire logic                          pready,
  input wire logic                          pslverr,
  // core
  input wire logic                          manager_reset,
  input wire logic                          step_done,
  input wire logic signed [31:0]            fine_delay_time,
  input wire logic [$clog2(NUM_TAPS+1)-1:0] tap_select
);
  logic [1:0]        mode_ff;
  logic signed [8:0] init_ff;
  logic [3:0]        quiet_ff;
  logic [7:0]        hi_ff;
  logic              wr_ok;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff  <= 2'h0;
      init_ff  <= 9'h000;
      quiet_ff <= 4'h0;
      hi_ff    <= 8'h00;
    end else begin
      hi_ff <= step_done ? hi_ff + 8'h01 : 8'h00;
      if (wr_ok && paddr == 8'h00) mode_ff <= pwdata[1:0];
      if (wr_ok && paddr == 8'h04) init_ff <= pwdata[8:0];
      if ((wr_ok && paddr < 8'h08) || manager_reset) quiet_ff <= 4'h0;
      else if (quiet_ff != 4'hf) quiet_ff <= quiet_ff + 4'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("access not two cycles");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_addr_a: assert property (psel && penable && pready |-> pslverr == (paddr > 8'h20))
    else $error("pslverr wrong for address");
  mgr_done_a: assert property (manager_reset |-> !step_done)
    else $error("done high in manager reset");
  done_len_a: assert property (disable iff (!presetn || manager_reset)
    $fell(step_done) |-> hi_ff inside {[38:42]})
    else $error("done not one step period");
  done_mode_a: assert property ($rose(step_done) |-> mode_ff == 2'h2)
    else $error("done outside variable mode");
  off_zero_a: assert property (quiet_ff == 4'hf && mode_ff[0] == mode_ff[1]
    |-> fine_delay_time == 0)
    else $error("delay nonzero when disabled");
  sign_a: assert property (quiet_ff == 4'hf && mode_ff == 2'h1
    |-> fine_delay_time == 0 || fine_delay_time[31] == init_ff[8])
    else $error("delay sign wrong");
  tap_range_a: assert property (tap_select <= NUM_TAPS)
    else $error("tap select beyond taps");
endmodule
bind fpsc_shifter fpsc_shifter_checker #(.NUM_TAPS(NUM_TAPS)) i_fpsc_shifter_checker (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .manager_reset(manager_reset), .step_done(step_done),
  .fine_delay_time(fine_delay_time), .tap_select(tap_select));

// ===== verif/tb_fine_phase_shift_control.sv
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin err_count++; \
  $display("mismatch at %0t: %s", $time, msg); end end
// ****
// bench top
// ****
module tb_fine_phase_shift_control;
  logic               pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]         paddr = 0;
  logic [31:0]        pwdata = 0, prdata;
  logic               pready, pslverr, manager_reset = 0, ref_clk = 0, fb_clk = 0;
  logic               step_enable, step_clock, step_direction, step_done;
  logic signed [31:0] fine_delay_time;
  logic [8:0]         tap_select;
  int                 err_count = 0, checked = 0;
  initial forever #2 pclk = ~pclk;
  initial #3 forever #20 ref_clk = ~ref_clk;
  initial #11 forever #20 fb_clk = ~fb_clk;
  fpsc_shifter #(.SETTLE_REF(4)) i_fpsc_shifter (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .manager_reset(manager_reset),
    .reference_clock_in(ref_clk), .feedback_clock_in(fb_clk), .step_enable(step_enable),
    .step_clock(step_clock), .step_direction(step_direction), .step_done(step_done),
    .fine_delay_time(fine_delay_time), .tap_select(tap_select));
  fpsc_step_model i_fpsc_step_model (.step_enable(step_enable), .step_clock(step_clock),
    .step_direction(step_direction), .step_done(step_done));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n == 16) begin
      err_count++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r; logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string m);
    logic [31:0] r; logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    `CHK(r, x, m)
  endtask
  task automatic chk_delay(input int s);
    int n, x, t;
    x = s * 10 * fpsc_pkg::PCLK_PERIOD_PS / fpsc_pkg::STEP_DIV;
    t = (x < 0 ? -x : x) / 40;
    if (t > 256) t = 256;
    for (n = 0; n < 200 && fine_delay_time !== x; n++) @(posedge pclk);
    `CHK(fine_delay_time, 32'(x), "delay port")
    // tap select follows the delay one cycle later
    @(posedge pclk);
    `CHK(tap_select, 9'(t), "tap select")
    rd(fpsc_pkg::REG_DELAY, 32'(x), "delay register");
  endtask
  task automatic stp(input logic act, req, dir, again, input int x);
    int h;
    i_fpsc_step_model.step(act, req, dir, again, h);
    `CHK(h, x, "done pulse count")
  endtask
  task automatic t_reset;
    logic [31:0] r; logic e;
    rd(fpsc_pkg::REG_CTRL, 0, "ctrl reset");
    rd(fpsc_pkg::REG_INIT, 0, "init reset");
    apb(1'b0, 8'h24, 32'h0000_0000, r, e);
    `CHK(e, 1'b1, "unmapped error")
    chk_delay(0);
    $display("reset test done");
  endtask
  task automatic t_fixed;
    wr(fpsc_pkg::REG_INIT, 32'h0000_0010);
    wr(fpsc_pkg::REG_CTRL, 32'h0000_0001);
    chk_delay(16);
    stp(1, 1, 1, 0, 0);
    rd(fpsc_pkg::REG_SHIFT, 0, "fixed ignores steps");
    wr(fpsc_pkg::REG_INIT, 32'hFFFF_FFF0);
    chk_delay(-16);
    wr(fpsc_pkg::REG_CTRL, 32'h0000_0000);
    chk_delay(0);
    stp(1, 1, 1, 0, 0);
    $display("fixed and off test done");
  endtask
  task automatic t_var;
    wr(fpsc_pkg::REG_INIT, 32'h0000_0010);
    wr(fpsc_pkg::REG_CTRL, 32'h0000_0002);
    chk_delay(16);
    stp(1, 1, 1, 1, 1);
    rd(fpsc_pkg::REG_SHIFT, 1, "one step up");
    chk_delay(17);
    stp(1, 1, 0, 0, 1);
    stp(1, 1, 0, 0, 1);
    stp(1, 0, 1, 0, 0);
    rd(fpsc_pkg::REG_SHIFT, 32'hFFFF_FFFF, "net count");
    chk_delay(15);
    manager_reset <= 1'b1;
    @(posedge pclk);
    manager_reset <= 1'b0;
    rd(fpsc_pkg::REG_SHIFT, 0, "reset clears count");
    chk_delay(16);
    wr(fpsc_pkg::REG_CTRL, 32'h0000_0016);
    stp(0, 1, 0, 0, 1);
    rd(fpsc_pkg::REG_SHIFT, 1, "inverted step");
    $display("variable test done");
  endtask
  task automatic t_ovf;
    wr(fpsc_pkg::REG_INIT, 32'h0000_00FF);
    wr(fpsc_pkg::REG_CTRL, 32'h0000_0002);
    stp(1, 1, 1, 0, 1);
    rd(fpsc_pkg::REG_SHIFT, 0, "count held at limit");
    rd(fpsc_pkg::REG_STATUS, 1, "overflow set");
    wr(fpsc_pkg::REG_INIT, 32'h0000_0000);
    wr(fpsc_pkg::REG_STATUS, 32'h0000_0001);
    rd(fpsc_pkg::REG_STATUS, 0, "overflow cleared");
    $display("overflow test done");
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_fixed();
    t_var();
    t_ovf();
    report_and_stop();
  end
endmodule
